// >>> hdl/flash_boot_writer.sv
module flash_boot_writer (
  // Clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RST_N,
  // Received bytes from the serial receiver
  input  wire logic                       RX_VALID,
  input  wire flash_boot_pkg::rx_byte_t   RX_BYTE,
  // Transmit bytes to the serial transmitter
  output logic                            TX_VALID,
  output flash_boot_pkg::byte_t           TX_DATA,
  input  wire logic                       TX_READY,
  input  wire logic                       TX_DONE,
  // Rate control
  input  wire logic [4:0]                 RATE_OK,
  output logic                            BAUD_AUTO,
  output flash_boot_pkg::byte_t           RATE_CODE,
  // Flash read port
  output logic                            MEM_RD_REQ,
  output flash_boot_pkg::faddr_t          MEM_RD_ADDR,
  input  wire logic                       MEM_RD_ACK,
  input  wire flash_boot_pkg::byte_t      MEM_RD_DATA,
  // Flash write stream and status
  input  wire logic                       PROTECT,
  output logic                            FLASH_WR_VALID,
  output flash_boot_pkg::flash_wr_t       FLASH_WR,
  output logic                            HALTED
);
  function automatic logic rate_valid(input flash_boot_pkg::byte_t code,
                                      input logic [4:0] ok);
    rate_valid = (code == flash_boot_pkg::RATE_9600   && ok[0]) ||
                 (code == flash_boot_pkg::RATE_CODE_B && ok[1]) ||
                 (code == flash_boot_pkg::RATE_CODE_C && ok[2]) ||
                 (code == flash_boot_pkg::RATE_CODE_D && ok[3]) ||
                 (code == flash_boot_pkg::RATE_CODE_E && ok[4]);
  endfunction : rate_valid
  flash_boot_pkg::state_t state_ff;
  flash_boot_pkg::byte_t  rate_pend_ff;
  flash_boot_pkg::byte_t  rate_ff;
  flash_boot_pkg::byte_t  err_code_ff;
  logic [3:0]             err_idx_ff;
  logic [2:0]             addr_idx_ff;
  logic [47:0]            addr_sh_ff;
  flash_boot_pkg::faddr_t rd_addr_ff;
  logic                   rd_req_ff;
  logic                   blank_ff;
  flash_boot_pkg::byte_t  pw_left_ff;
  flash_boot_pkg::byte_t  pw_byte_ff;
  logic [2:0]             field_ff;
  flash_boot_pkg::byte_t  rec_len_ff;
  flash_boot_pkg::byte_t  rec_cnt_ff;
  logic [15:0]            rec_addr_ff;
  flash_boot_pkg::byte_t  rec_type_ff;
  flash_boot_pkg::byte_t  rec_sum_ff;
  logic [15:0]            sum_ff;
  logic                   wr_valid_ff;
  flash_boot_pkg::flash_wr_t wr_ff;
  // Two-entry transmit buffer.
  flash_boot_pkg::byte_t  txb_mem_ff [2];
  logic                   txb_wr_ff;
  logic                   txb_rd_ff;
  logic [1:0]             txb_cnt_ff;
  logic                   tx_valid_ff;
  flash_boot_pkg::byte_t  tx_data_ff;
  logic                   push;
  flash_boot_pkg::byte_t  push_data;
  logic                   space;
  logic                   pop;
  logic [1:0]             nxt_cnt;
  logic                   nxt_rd;
  logic                   rx_take;
  logic                   rx_bad;
  flash_boot_pkg::byte_t  rx_d;
  flash_boot_pkg::byte_t  err_byte;
  flash_boot_pkg::byte_t  next_sum;
  assign space   = txb_cnt_ff != flash_boot_pkg::TXB_DEPTH;
  assign rx_take = RX_VALID && !RX_BYTE.err;
  assign rx_bad  = RX_VALID && RX_BYTE.err;
  assign rx_d    = RX_BYTE.data;
  assign next_sum = rec_sum_ff + rx_d;
  assign err_byte = (err_idx_ff < flash_boot_pkg::ERR_PREFIX_B_IDX) ?
                      flash_boot_pkg::ERR_PREFIX_A :
                    (err_idx_ff < flash_boot_pkg::ERR_CODE_IDX) ?
                      flash_boot_pkg::ERR_PREFIX_B : err_code_ff;
  // Every transmitted byte goes through the buffer; the sequencer waits for space.
  always_comb begin
    push      = space;
    push_data = err_byte;
    case (state_ff)
      flash_boot_pkg::S_ECHO_MATCH: push_data = flash_boot_pkg::MATCH_BYTE;
      flash_boot_pkg::S_ECHO_RATE:  push_data = rate_pend_ff;
      flash_boot_pkg::S_ECHO_CMD:   push_data = flash_boot_pkg::CMD_WRITE;
      flash_boot_pkg::S_SUM_HI:     push_data = sum_ff[15:8];
      flash_boot_pkg::S_SUM_LO:     push_data = sum_ff[7:0];
      flash_boot_pkg::S_ERR_SEQ:    push_data = err_byte;
      default:                      push      = 1'b0;
    endcase
  end
  // Protocol sequencer.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_ff     <= flash_boot_pkg::S_MATCH;
      rate_pend_ff <= flash_boot_pkg::RATE_9600;
      err_code_ff  <= flash_boot_pkg::ERR_RATE;
      err_idx_ff   <= 4'h0;
      addr_idx_ff  <= 3'h0;
      addr_sh_ff   <= 48'h0000_0000_0000;
      rd_addr_ff   <= 24'h00_0000;
      rd_req_ff    <= 1'b0;
      blank_ff     <= 1'b1;
      pw_left_ff   <= 8'h00;
      pw_byte_ff   <= 8'h00;
      field_ff     <= flash_boot_pkg::FLD_LEN;
      rec_len_ff   <= 8'h00;
      rec_cnt_ff   <= 8'h00;
      rec_addr_ff  <= 16'h0000;
      rec_type_ff  <= 8'h00;
      rec_sum_ff   <= 8'h00;
      sum_ff       <= 16'h0000;
    end else begin
      case (state_ff)
        flash_boot_pkg::S_MATCH: begin
          // A garbled attempt is dropped silently and matching goes on.
          if (rx_take && rx_d == flash_boot_pkg::MATCH_BYTE) begin
            state_ff <= flash_boot_pkg::S_ECHO_MATCH;
          end
        end
        flash_boot_pkg::S_ECHO_MATCH: if (push) state_ff <= flash_boot_pkg::S_RATE;
        flash_boot_pkg::S_RATE: begin
          if (rx_bad) begin
            state_ff <= flash_boot_pkg::S_HALT;
          end else if (rx_take && rate_valid(rx_d, RATE_OK)) begin
            rate_pend_ff <= rx_d;
            state_ff     <= flash_boot_pkg::S_ECHO_RATE;
          end else if (rx_take) begin
            err_code_ff <= flash_boot_pkg::ERR_RATE;
            err_idx_ff  <= 4'h0;
            state_ff    <= flash_boot_pkg::S_ERR_SEQ;
          end
        end
        flash_boot_pkg::S_ECHO_RATE: if (push) state_ff <= flash_boot_pkg::S_RATE_WAIT;
        flash_boot_pkg::S_RATE_WAIT: begin
          // The new rate applies only once the echo has fully left the line.
          if (TX_DONE && txb_cnt_ff == 2'h0 && !tx_valid_ff) begin
            state_ff <= flash_boot_pkg::S_CMD;
          end
        end
        flash_boot_pkg::S_CMD: begin
          if (rx_bad) begin
            state_ff <= flash_boot_pkg::S_HALT;
          end else if (rx_take && rx_d == flash_boot_pkg::CMD_WRITE) begin
            state_ff <= flash_boot_pkg::S_ECHO_CMD;
          end else if (rx_take) begin
            err_code_ff <= flash_boot_pkg::ERR_CMD;
            err_idx_ff  <= 4'h0;
            state_ff    <= flash_boot_pkg::S_ERR_SEQ;
          end
        end
        flash_boot_pkg::S_ECHO_CMD: begin
          if (push) begin
            addr_idx_ff <= 3'h0;
            sum_ff      <= 16'h0000;
            state_ff    <= flash_boot_pkg::S_ADDR;
          end
        end
        flash_boot_pkg::S_ADDR: begin
          if (rx_bad) begin
            state_ff <= flash_boot_pkg::S_HALT;
          end else if (rx_take) begin
            addr_sh_ff  <= {addr_sh_ff[39:0], rx_d};
            addr_idx_ff <= addr_idx_ff + 3'h1;
            if (addr_idx_ff == flash_boot_pkg::ADDR_BYTES_LAST) begin
              state_ff <= flash_boot_pkg::S_PROT_CHK;
            end
          end
        end
        flash_boot_pkg::S_PROT_CHK: begin
          // An address beyond the flash space counts as a password error.
          if (PROTECT || addr_sh_ff[47:44] != flash_boot_pkg::ADDR_TOP_ZERO ||
              addr_sh_ff[23:20] != flash_boot_pkg::ADDR_TOP_ZERO) begin
            state_ff <= flash_boot_pkg::S_HALT;
          end else begin
            rd_addr_ff <= flash_boot_pkg::BLANK_FIRST;
            blank_ff   <= 1'b1;
            state_ff   <= flash_boot_pkg::S_BLANK_RD;
          end
        end
        flash_boot_pkg::S_BLANK_RD: begin
          rd_req_ff <= !MEM_RD_ACK;
          if (rd_req_ff && MEM_RD_ACK) begin
            if (rd_addr_ff == flash_boot_pkg::BLANK_LAST) begin
              if (blank_ff && MEM_RD_DATA == flash_boot_pkg::ERASED) begin
                state_ff <= flash_boot_pkg::S_HEX_IDLE;
              end else begin
                rd_addr_ff <= addr_sh_ff[47:24];
                state_ff   <= flash_boot_pkg::S_CNT_RD;
              end
            end else begin
              rd_addr_ff <= rd_addr_ff + 24'h00_0001;
            end
            if (MEM_RD_DATA != flash_boot_pkg::ERASED) blank_ff <= 1'b0;
          end
        end
        flash_boot_pkg::S_CNT_RD: begin
          rd_req_ff <= !MEM_RD_ACK;
          if (rd_req_ff && MEM_RD_ACK) begin
            pw_left_ff <= MEM_RD_DATA;
            rd_addr_ff <= addr_sh_ff[23:0];
            state_ff   <= (MEM_RD_DATA == 8'h00) ? flash_boot_pkg::S_HEX_IDLE
                                                 : flash_boot_pkg::S_PW_RX;
          end
        end
        flash_boot_pkg::S_PW_RX: begin
          if (rx_bad) begin
            state_ff <= flash_boot_pkg::S_HALT;
          end else if (rx_take) begin
            pw_byte_ff <= rx_d;
            state_ff   <= flash_boot_pkg::S_PW_RD;
          end
        end
        flash_boot_pkg::S_PW_RD: begin
          rd_req_ff <= !MEM_RD_ACK;
          if (rd_req_ff && MEM_RD_ACK) begin
            if (MEM_RD_DATA != pw_byte_ff) begin
              state_ff <= flash_boot_pkg::S_HALT;
            end else begin
              rd_addr_ff <= rd_addr_ff + 24'h00_0001;
              pw_left_ff <= pw_left_ff - 8'h01;
              state_ff   <= (pw_left_ff == 8'h01) ? flash_boot_pkg::S_HEX_IDLE
                                                  : flash_boot_pkg::S_PW_RX;
            end
          end
        end
        flash_boot_pkg::S_HEX_IDLE: begin
          if (rx_bad) begin
            state_ff <= flash_boot_pkg::S_HALT;
          end else if (rx_take && rx_d == flash_boot_pkg::REC_START) begin
            field_ff   <= flash_boot_pkg::FLD_LEN;
            rec_sum_ff <= 8'h00;
            state_ff   <= flash_boot_pkg::S_HEX_REC;
          end
        end
        flash_boot_pkg::S_HEX_REC: begin
          if (rx_bad) begin
            state_ff <= flash_boot_pkg::S_HALT;
          end else if (rx_take) begin
            rec_sum_ff <= next_sum;
            case (field_ff)
              flash_boot_pkg::FLD_LEN: begin
                rec_len_ff <= rx_d;
                rec_cnt_ff <= 8'h00;
                field_ff   <= flash_boot_pkg::FLD_AHI;
              end
              flash_boot_pkg::FLD_AHI: begin
                rec_addr_ff[15:8] <= rx_d;
                field_ff          <= flash_boot_pkg::FLD_ALO;
              end
              flash_boot_pkg::FLD_ALO: begin
                rec_addr_ff[7:0] <= rx_d;
                field_ff         <= flash_boot_pkg::FLD_TYPE;
              end
              flash_boot_pkg::FLD_TYPE: begin
                rec_type_ff <= rx_d;
                if (!(rx_d == flash_boot_pkg::REC_DATA ||
                      (rx_d == flash_boot_pkg::REC_END && rec_len_ff == 8'h00))) begin
                  state_ff <= flash_boot_pkg::S_HALT;
                end
                field_ff <= (rec_len_ff == 8'h00) ? flash_boot_pkg::FLD_CHK
                                                  : flash_boot_pkg::FLD_DATA;
              end
              flash_boot_pkg::FLD_DATA: begin
                sum_ff     <= sum_ff + {8'h00, rx_d};
                rec_cnt_ff <= rec_cnt_ff + 8'h01;
                if (rec_cnt_ff + 8'h01 == rec_len_ff) field_ff <= flash_boot_pkg::FLD_CHK;
              end
              default: begin
                // The record's own checksum makes the byte sum wrap to zero.
                if (next_sum != 8'h00) begin
                  state_ff <= flash_boot_pkg::S_HALT;
                end else if (rec_type_ff == flash_boot_pkg::REC_END) begin
                  state_ff <= flash_boot_pkg::S_SUM_HI;
                end else begin
                  state_ff <= flash_boot_pkg::S_HEX_IDLE;
                end
              end
            endcase
          end
        end
        flash_boot_pkg::S_SUM_HI: if (push) state_ff <= flash_boot_pkg::S_SUM_LO;
        flash_boot_pkg::S_SUM_LO: if (push) state_ff <= flash_boot_pkg::S_CMD;
        flash_boot_pkg::S_ERR_SEQ: begin
          if (push) begin
            err_idx_ff <= err_idx_ff + 4'h1;
            if (err_idx_ff == flash_boot_pkg::ERR_LAST_IDX) state_ff <= flash_boot_pkg::S_HALT;
          end
        end
        flash_boot_pkg::S_HALT: state_ff <= flash_boot_pkg::S_HALT;
        default: state_ff <= flash_boot_pkg::S_HALT;
      endcase
    end
  end
  // Active rate: 9600 on match, new code only after its echo has gone out.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rate_ff <= flash_boot_pkg::RATE_9600;
    end else if (state_ff == flash_boot_pkg::S_MATCH && rx_take &&
                 rx_d == flash_boot_pkg::MATCH_BYTE) begin
      rate_ff <= flash_boot_pkg::RATE_9600;
    end else if (state_ff == flash_boot_pkg::S_RATE_WAIT && TX_DONE &&
                 txb_cnt_ff == 2'h0 && !tx_valid_ff) begin
      rate_ff <= rate_pend_ff;
    end
  end
  // Write stream: one pulse per accepted data byte.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_valid_ff <= 1'b0;
      wr_ff       <= '0;
    end else begin
      wr_valid_ff <= state_ff == flash_boot_pkg::S_HEX_REC && rx_take &&
                     field_ff == flash_boot_pkg::FLD_DATA;
      wr_ff.addr  <= {8'h00, rec_addr_ff + {8'h00, rec_cnt_ff}};
      wr_ff.data  <= rx_d;
    end
  end
  // Buffer pointers; the registered head keeps TX_DATA glitch free.
  assign pop     = tx_valid_ff && TX_READY;
  assign nxt_cnt = txb_cnt_ff + {1'b0, push} - {1'b0, pop};
  assign nxt_rd  = pop ? !txb_rd_ff : txb_rd_ff;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      txb_mem_ff[0] <= 8'h00;
      txb_mem_ff[1] <= 8'h00;
      txb_wr_ff     <= 1'b0;
      txb_rd_ff     <= 1'b0;
      txb_cnt_ff    <= 2'h0;
      tx_valid_ff   <= 1'b0;
      tx_data_ff    <= 8'h00;
    end else begin
      if (push) begin
        txb_mem_ff[txb_wr_ff] <= push_data;
        txb_wr_ff             <= !txb_wr_ff;
      end
      txb_rd_ff   <= nxt_rd;
      txb_cnt_ff  <= nxt_cnt;
      tx_valid_ff <= nxt_cnt != 2'h0;
      tx_data_ff  <= (push && nxt_cnt == 2'h1 && (txb_cnt_ff == 2'h0 || pop)) ?
                     push_data : txb_mem_ff[nxt_rd];
    end
  end
  // Status outputs.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      BAUD_AUTO <= 1'b1;
      HALTED    <= 1'b0;
    end else begin
      BAUD_AUTO <= state_ff == flash_boot_pkg::S_MATCH;
      HALTED    <= state_ff == flash_boot_pkg::S_HALT;
    end
  end
  assign TX_VALID       = tx_valid_ff;
  assign TX_DATA        = tx_data_ff;
  assign RATE_CODE      = rate_ff;
  assign MEM_RD_REQ     = rd_req_ff;
  assign MEM_RD_ADDR    = rd_addr_ff;
  assign FLASH_WR_VALID = wr_valid_ff;
  assign FLASH_WR       = wr_ff;
endmodule : flash_boot_writer

// >>> include/flash_boot_pkg.sv
// Function
// - After start, wait for 5AH and tune receiver to initial 9600 bps.
// - Echo 5AH when matched; otherwise send nothing and keep matching.
// - Echo a valid rate code, switching rate only after echo completes.
// - Invalid rate code: send A1H x3, A3H x3, 62H x3, then halt.
// - Command 30H selects writing and is echoed unchanged.
// - Invalid command: send A1H x3, A3H x3, 63H x3, then halt.
// - Bytes one to four at 9600 bps, later bytes at the new rate.
// - Receive password count address, high byte first, without reply.
// - Receive password compare start address, high byte first, without reply.
// - Address byte reception or password error: halt silently.
// - Read count N, compare N received bytes against stored bytes.
// - All FFH from FFFE0H to FFFFFH means blank: skip password.
// - Read protection or password mismatch halts serial communication.
// - Receive hex records, then return 16-bit checksum, upper byte first.
// - After checksum, wait for next command at the modified rate.
// - Ignore bytes until record start 3AH; echo no record data.
// - Reception error or malformed record halts without error code.
// - Checksum sent only after a clean end record.
package flash_boot_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [23:0] faddr_t;

  typedef struct packed {
    logic  err;
    byte_t data;
  } rx_byte_t;

  typedef struct packed {
    faddr_t addr;
    byte_t  data;
  } flash_wr_t;

  typedef enum logic [4:0] {
    S_MATCH      = 5'h00,
    S_ECHO_MATCH = 5'h01,
    S_RATE       = 5'h02,
    S_ECHO_RATE  = 5'h03,
    S_RATE_WAIT  = 5'h04,
    S_CMD        = 5'h05,
    S_ECHO_CMD   = 5'h06,
    S_ADDR       = 5'h07,
    S_PROT_CHK   = 5'h08,
    S_BLANK_RD   = 5'h09,
    S_CNT_RD     = 5'h0A,
    S_PW_RX      = 5'h0B,
    S_PW_RD      = 5'h0C,
    S_HEX_IDLE   = 5'h0D,
    S_HEX_REC    = 5'h0E,
    S_SUM_HI     = 5'h0F,
    S_SUM_LO     = 5'h10,
    S_ERR_SEQ    = 5'h11,
    S_HALT       = 5'h12
  } state_t;

  localparam byte_t  MATCH_BYTE   = 8'h5A;
  localparam byte_t  RATE_9600    = 8'h28;
  localparam byte_t  RATE_CODE_B  = 8'h18;
  localparam byte_t  RATE_CODE_C  = 8'h10;
  localparam byte_t  RATE_CODE_D  = 8'h08;
  localparam byte_t  RATE_CODE_E  = 8'h04;
  localparam byte_t  CMD_WRITE    = 8'h30;
  localparam byte_t  ERR_PREFIX_A = 8'hA1;
  localparam byte_t  ERR_PREFIX_B = 8'hA3;
  localparam byte_t  ERR_RATE     = 8'h62;
  localparam byte_t  ERR_CMD      = 8'h63;
  localparam byte_t  REC_START    = 8'h3A;
  localparam byte_t  ERASED       = 8'hFF;
  localparam byte_t  REC_DATA     = 8'h00;
  localparam byte_t  REC_END      = 8'h01;
  localparam faddr_t BLANK_FIRST  = 24'h0F_FFE0;
  localparam faddr_t BLANK_LAST   = 24'h0F_FFFF;
  localparam logic [3:0] ADDR_TOP_ZERO = 4'h0;
  localparam logic [2:0] ADDR_BYTES_LAST = 3'h5;
  localparam logic [3:0] ERR_LAST_IDX  = 4'h8;
  localparam logic [3:0] ERR_PREFIX_B_IDX = 4'h3;
  localparam logic [3:0] ERR_CODE_IDX  = 4'h6;
  localparam logic [2:0] FLD_LEN   = 3'h0;
  localparam logic [2:0] FLD_AHI   = 3'h1;
  localparam logic [2:0] FLD_ALO   = 3'h2;
  localparam logic [2:0] FLD_TYPE  = 3'h3;
  localparam logic [2:0] FLD_DATA  = 3'h4;
  localparam logic [2:0] FLD_CHK   = 3'h5;
  localparam logic [1:0] TXB_DEPTH = 2'h2;

endpackage : flash_boot_pkg

// >>> sim/flash_boot_writer_assertions.sv
module flash_boot_writer_assertions (
  // Clock and reset
  input wire logic                     CLK,
  input wire logic                     RST_N,
  // Watched ports
  input wire logic                     RX_VALID,
  input wire flash_boot_pkg::rx_byte_t RX_BYTE,
  input wire logic                     TX_VALID,
  input wire flash_boot_pkg::byte_t    TX_DATA,
  input wire logic                     TX_READY,
  input wire logic                     TX_DONE,
  input wire logic                     BAUD_AUTO,
  input wire flash_boot_pkg::byte_t    RATE_CODE,
  input wire logic                     MEM_RD_REQ,
  input wire flash_boot_pkg::faddr_t   MEM_RD_ADDR,
  input wire logic                     MEM_RD_ACK,
  input wire logic                     FLASH_WR_VALID,
  input wire logic                     HALTED
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_match_in;
    BAUD_AUTO && !HALTED && RX_VALID && !RX_BYTE.err
      && RX_BYTE.data == flash_boot_pkg::MATCH_BYTE;
  endsequence
  sequence s_echo_out;
    ##[1:4] TX_VALID && TX_DATA == flash_boot_pkg::MATCH_BYTE;
  endsequence
  a_match_echo: assert property (s_match_in |-> s_echo_out)
    else $error("matching byte not echoed");
  a_no_echo: assert property (BAUD_AUTO && RX_VALID && (RX_BYTE.err
    || RX_BYTE.data != flash_boot_pkg::MATCH_BYTE) |=> !TX_VALID [*4])
    else $error("echo sent for a wrong matching byte");
  a_rate_switch: assert property ($changed(RATE_CODE) |-> $past(TX_DONE) && !$past(TX_VALID))
    else $error("rate changed before the echo finished");
  a_halt_sticky: assert property (HALTED |=> HALTED)
    else $error("halt left without reset");
  a_halt_quiet: assert property (HALTED && !TX_VALID |=> !TX_VALID && !FLASH_WR_VALID)
    else $error("activity after halt");
  a_mem_hold: assert property (MEM_RD_REQ && !MEM_RD_ACK |=> MEM_RD_REQ && $stable(MEM_RD_ADDR))
    else $error("read request dropped early");
  a_mem_drop: assert property (MEM_RD_REQ && MEM_RD_ACK |=> !MEM_RD_REQ)
    else $error("read request held after ack");
  a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("transmit byte changed while stalled");
endmodule : flash_boot_writer_assertions

bind flash_boot_writer flash_boot_writer_assertions u_chk (
  .CLK(CLK), .RST_N(RST_N), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE),
  .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY), .TX_DONE(TX_DONE),
  .BAUD_AUTO(BAUD_AUTO), .RATE_CODE(RATE_CODE), .MEM_RD_REQ(MEM_RD_REQ),
  .MEM_RD_ADDR(MEM_RD_ADDR), .MEM_RD_ACK(MEM_RD_ACK),
  .FLASH_WR_VALID(FLASH_WR_VALID), .HALTED(HALTED)
);

// >>> sim/serial_far_side.sv
module serial_far_side (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Behaviour control
  input  wire logic                  slow,
  input  wire flash_boot_pkg::byte_t mem_fill,
  // Transmitter side
  input  wire logic                  tx_valid,
  input  wire flash_boot_pkg::byte_t tx_data,
  output logic                       tx_ready,
  output logic                       tx_done,
  output logic                       got,
  output flash_boot_pkg::byte_t      got_byte,
  // Flash read side
  input  wire logic                  rd_req,
  output logic                       rd_ack,
  output flash_boot_pkg::byte_t      rd_data
);
  logic [2:0]            busy_ff;
  logic [1:0]            gap_ff;
  logic [1:0]            lat_ff;
  flash_boot_pkg::byte_t hold_ff;
  // One byte shifts at a time; slow mode also blocks most cycles to fill the buffer.
  assign tx_ready = busy_ff == 3'h0 && (!slow || gap_ff == 2'h0);
  // Outside the ack the data lines show the inverse so no stale byte passes.
  assign rd_data  = rd_ack ? mem_fill : ~mem_fill;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_ff <= 3'h0;
      tx_done <= 1'b0;
      got     <= 1'b0;
    end else begin
      tx_done <= busy_ff == 3'h1;
      got     <= busy_ff == 3'h1;
      if (tx_valid && tx_ready) begin
        busy_ff <= 3'h4;
        hold_ff <= tx_data;
      end else if (busy_ff != 3'h0) begin
        busy_ff <= busy_ff - 3'h1;
      end
      got_byte <= hold_ff;
    end
  end
  always_ff @(posedge clk) begin
    gap_ff <= rst_n ? gap_ff + 2'h1 : 2'h0;
    rd_ack <= rst_n && rd_req && !rd_ack && lat_ff == 2'h2;
    lat_ff <= (rst_n && rd_req && !rd_ack) ? lat_ff + 2'h1 : 2'h0;
  end
endmodule : serial_far_side

// >>> sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      clk = 1'b0;
  logic                      rst_n = 1'b0;
  logic                      rx_valid = 1'b0;
  flash_boot_pkg::rx_byte_t  rx_byte = '0;
  logic [4:0]                rate_ok = 5'h1F;
  logic                      protect = 1'b0;
  logic                      slow = 1'b0;
  flash_boot_pkg::byte_t     fill = 8'hFF;
  logic                      tx_valid, tx_ready, tx_done, baud_auto, rd_req, rd_ack;
  logic                      wr_valid, halted, got;
  flash_boot_pkg::byte_t     tx_data, rate_code, rd_data, got_byte;
  flash_boot_pkg::faddr_t    rd_addr;
  flash_boot_pkg::flash_wr_t wr, wr_seen;
  flash_boot_pkg::byte_t     rxq[$];
  flash_boot_pkg::byte_t     rec[14] = '{8'h77, 8'h3A, 8'h01, 8'h00, 8'h10, 8'h00, 8'hAB,
                                         8'h44, 8'h3A, 8'h00, 8'h00, 8'h00, 8'h01, 8'hFF};
  int                        wr_n = 0;
  int                        fail_count = 0;
  int                        tests_run = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (got) rxq.push_back(got_byte);
    if (wr_valid) begin
      wr_seen = wr;
      wr_n++;
    end
  end
  flash_boot_writer dut (.CLK(clk), .RST_N(rst_n), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
    .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready), .TX_DONE(tx_done),
    .RATE_OK(rate_ok), .BAUD_AUTO(baud_auto), .RATE_CODE(rate_code), .MEM_RD_REQ(rd_req),
    .MEM_RD_ADDR(rd_addr), .MEM_RD_ACK(rd_ack), .MEM_RD_DATA(rd_data), .PROTECT(protect),
    .FLASH_WR_VALID(wr_valid), .FLASH_WR(wr), .HALTED(halted));
  serial_far_side far (.clk(clk), .rst_n(rst_n), .slow(slow), .mem_fill(fill),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .tx_done(tx_done),
    .got(got), .got_byte(got_byte), .rd_req(rd_req), .rd_ack(rd_ack), .rd_data(rd_data));
  task automatic test_done();
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic send(input flash_boot_pkg::byte_t b, input logic e = 1'b0);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_byte  = '{err: e, data: b};
    @(negedge clk);
    rx_valid = 1'b0;
    repeat (12) @(negedge clk);
  endtask : send
  task automatic wait_rx(input int n);
    for (int i = 0; i < 3000 && rxq.size() < n; i++) @(negedge clk);
    if (rxq.size() < n) begin
      chk("reply count", n, rxq.size());
      test_done();
    end
  endtask : wait_rx
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rxq.delete();
  endtask : do_reset
  task automatic head(input flash_boot_pkg::byte_t rt, input flash_boot_pkg::byte_t cm, int n);
    do_reset();
    send(flash_boot_pkg::MATCH_BYTE);
    wait_rx(1);
    send(rt);
    if (n == 10) wait_rx(10);
    else begin
      wait_rx(2);
      send(cm);
      wait_rx(n);
    end
  endtask : head
  task automatic addr6(input flash_boot_pkg::byte_t hi);
    send(hi);
    repeat (5) send(8'h00);
    repeat (300) @(negedge clk);
  endtask : addr6
  task automatic err9(input int s, input flash_boot_pkg::byte_t code);
    for (int i = 0; i < 9; i++) chk("error byte", i < 3 ? 8'hA1 : i < 6 ? 8'hA3 : code, rxq[s + i]);
    repeat (6) @(negedge clk);
    chk("halted", 1'b1, halted);
  endtask : err9
  task automatic t_match();
    do_reset();
    chk("baud auto", 1'b1, baud_auto);
    chk("reset rate", 8'h28, rate_code);
    send(8'h55);
    send(8'h5A, 1'b1);
    chk("no echo", 0, rxq.size());
    send(8'h5A);
    wait_rx(1);
    chk("echo", 8'h5A, rxq[0]);
    chk("baud auto", 1'b0, baud_auto);
    $display("test match done");
  endtask : t_match
  task automatic t_errors();
    slow    = 1'b1;
    rate_ok = 5'h1D;
    head(flash_boot_pkg::RATE_CODE_B, 8'h00, 10);
    err9(1, 8'h62);
    send(8'h5A);
    send(8'h28);
    chk("halt silent", 10, rxq.size());
    rate_ok = 5'h1F;
    head(flash_boot_pkg::RATE_9600, 8'hF0, 11);
    wait_rx(11);
    err9(2, 8'h63);
    slow = 1'b0;
    $display("test errors done");
  endtask : t_errors
  task automatic t_write();
    head(flash_boot_pkg::RATE_CODE_B, flash_boot_pkg::CMD_WRITE, 3);
    chk("rate code", 8'h18, rate_code);
    chk("cmd echo", 8'h30, rxq[2]);
    addr6(8'h00);
    chk("addr silent", 3, rxq.size());
    foreach (rec[i]) send(rec[i]);
    wait_rx(5);
    chk("sum hi", 8'h00, rxq[3]);
    chk("sum lo", 8'hAB, rxq[4]);
    chk("writes", 1, wr_n);
    chk("write", {24'h00_0010, 8'hAB}, wr_seen);
    send(flash_boot_pkg::CMD_WRITE);
    wait_rx(6);
    chk("next cmd", 8'h30, rxq[5]);
    addr6(8'h00);
    for (int i = 8; i < 13; i++) send(rec[i]);
    send(8'h00);
    chk("record halt", 1'b1, halted);
    chk("record silent", 6, rxq.size());
    $display("test write done");
  endtask : t_write
  task automatic t_stop(input flash_boot_pkg::byte_t hi, input logic prot);
    head(flash_boot_pkg::RATE_9600, flash_boot_pkg::CMD_WRITE, 3);
    protect = prot;
    fill    = 8'h02;
    addr6(hi);
    if (!prot && hi == 8'h00) begin
      send(8'h02);
      chk("first pw", 1'b0, halted);
      send(8'h05);
      chk("read addr", 24'h00_0001, rd_addr);
    end
    chk("stop halted", 1'b1, halted);
    chk("stop silent", 3, rxq.size());
    protect = 1'b0;
    fill    = 8'hFF;
    $display("test stop done");
  endtask : t_stop
  initial begin
    t_match();
    t_errors();
    t_write();
    t_stop(8'h10, 1'b0);
    t_stop(8'h00, 1'b1);
    t_stop(8'h00, 1'b0);
    test_done();
  end
endmodule : tb
